// file: hw/atc_pkg.sv
// Constants shared by the auxiliary timer design
package atc_pkg;

    // ------------------------------------------------------------
    // Bus widths and register byte offsets
    // ------------------------------------------------------------
    localparam int AXI_DATA_W = 32;
    localparam int AXI_STRB_W = 4;
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_RELOAD = 8'h08;
    localparam logic [7:0] OFS_MODE = 8'h0C;
    localparam logic [7:0] OFS_POWER = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1C;

    // ------------------------------------------------------------
    // Control register bit positions
    // ------------------------------------------------------------
    localparam int CTL_OVF = 7;
    localparam int CTL_EXT = 6;
    localparam int CTL_A_RX = 5;
    localparam int CTL_A_TX = 4;
    localparam int CTL_EXEN = 3;
    localparam int CTL_RUN = 2;
    localparam int CTL_CSEL = 1;
    localparam int CTL_CPRL = 0;

    // Power control register bit positions (second serial port)
    localparam int PWR_B_RX = 1;
    localparam int PWR_B_TX = 0;

    // Interrupt status bit positions
    localparam int IRQ_OVF = 0;
    localparam int IRQ_EXT = 1;

    // ------------------------------------------------------------
    // Reset values and fixed figures
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] RST_RELOAD = 16'h0000;
    localparam logic [15:0] COUNT_TOP = 16'hFFFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: hw/atc_timer.sv
// Auxiliary 16-bit timer/counter with capture, reload and baud modes
`timescale 1ns/10ps

module atc_timer
#(
    parameter int ADDR_W = 8
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic external_count_input,
    input wire logic external_trigger_input,
    input wire logic timer1_overflow,
    output logic uart_a_rx_clock,
    output logic uart_a_tx_clock,
    output logic uart_b_rx_clock,
    output logic uart_b_tx_clock,
    output logic aux_overflow_pulse,
    output logic timer_irq,
    output logic irq,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [atc_pkg::AXI_DATA_W-1:0] s_axi_wdata,
    input wire logic [atc_pkg::AXI_STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [atc_pkg::AXI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import atc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] count;
        logic [15:0] reload;
        logic down_en;
        logic [1:0] pwr;
        logic [1:0] sts;
        logic [1:0] ien;
        logic cnt_in_d;
        logic trig_d;
        logic ovf_pulse;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } atc_state_t;

    atc_state_t st_r;
    atc_state_t st_nxt;

    logic baud;
    logic tick;
    logic trig_fall;
    logic ext_evt;
    logic capture_mode;
    logic count_down;
    logic roll;
    logic wr_go;
    logic [7:0] wr_addr;
    logic [7:0] rd_addr;

    // Byte-lane merge for registers up to 16 bits wide
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0])
            res[7:0] = wd[7:0];
        if (strb[1])
            res[15:8] = wd[15:8];
        return res;
    endfunction

    function automatic logic known_addr(input logic [7:0] a);
        return a == OFS_CONTROL || a == OFS_COUNT || a == OFS_RELOAD ||
               a == OFS_MODE || a == OFS_POWER || a == OFS_IRQ_STATUS ||
               a == OFS_IRQ_CLEAR || a == OFS_IRQ_ENABLE;
    endfunction

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    assign baud = st_r.ctrl[CTL_A_RX] | st_r.ctrl[CTL_A_TX] |
                  st_r.pwr[PWR_B_RX] | st_r.pwr[PWR_B_TX];
    assign tick = st_r.ctrl[CTL_CSEL] ?
                  (st_r.cnt_in_d & ~external_count_input) : 1'b1;
    assign trig_fall = st_r.trig_d & ~external_trigger_input;
    assign ext_evt = trig_fall & st_r.ctrl[CTL_EXEN];
    assign capture_mode = st_r.ctrl[CTL_CPRL] & ~baud;
    // Direction follows the trigger pin level only in plain reload mode
    assign count_down = ~capture_mode & ~baud & st_r.down_en &
                        ~external_trigger_input;
    assign roll = st_r.ctrl[CTL_RUN] & tick &
                  (count_down ? (st_r.count == st_r.reload)
                              : (st_r.count == COUNT_TOP));
    assign wr_go = st_r.aw_got & st_r.w_got;
    assign wr_addr = st_r.awaddr;
    assign rd_addr = 8'(s_axi_araddr);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.ovf_pulse = 1'b0;
        st_nxt.cnt_in_d = external_count_input;
        st_nxt.trig_d = external_trigger_input;

        // Counting; a clear run bit stops ticking, not trigger reloads or writes
        if (st_r.ctrl[CTL_RUN] && tick)
        begin
            if (roll)
            begin
                st_nxt.ovf_pulse = 1'b1;
                if (capture_mode)
                    st_nxt.count = 16'h0000;
                else if (count_down)
                    st_nxt.count = COUNT_TOP;
                else
                    st_nxt.count = st_r.reload;
            end
            else if (count_down)
                st_nxt.count = st_r.count - 16'h0001;
            else
                st_nxt.count = st_r.count + 16'h0001;
        end

        // Trigger edge: baud use only raises the flag
        if (ext_evt && !baud)
        begin
            if (capture_mode)
                st_nxt.reload = st_r.count;
            else
                st_nxt.count = st_r.reload;
        end

        // Register writes, taken once address and data are both held
        if (wr_go)
        begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = known_addr(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            case (wr_addr)
                OFS_CONTROL:
                    if (st_r.wstrb[0])
                        st_nxt.ctrl = st_r.wdata[7:0];
                OFS_COUNT:
                    st_nxt.count = merge16(st_nxt.count, st_r.wdata,
                                           st_r.wstrb);
                OFS_RELOAD:
                    st_nxt.reload = merge16(st_nxt.reload, st_r.wdata,
                                            st_r.wstrb);
                OFS_MODE:
                    if (st_r.wstrb[0])
                        st_nxt.down_en = st_r.wdata[0];
                OFS_POWER:
                    if (st_r.wstrb[0])
                        st_nxt.pwr = st_r.wdata[1:0];
                OFS_IRQ_CLEAR:
                    if (st_r.wstrb[0])
                        st_nxt.sts = st_r.sts & ~st_r.wdata[1:0];
                OFS_IRQ_ENABLE:
                    if (st_r.wstrb[0])
                        st_nxt.ien = st_r.wdata[1:0];
                default:
                    st_nxt.ctrl = st_nxt.ctrl;
            endcase
        end

        // Hardware sets win over a software clear in the same cycle
        if (roll && !baud)
        begin
            st_nxt.ctrl[CTL_OVF] = 1'b1;
            st_nxt.sts[IRQ_OVF] = 1'b1;
        end
        if (ext_evt)
        begin
            st_nxt.ctrl[CTL_EXT] = 1'b1;
            st_nxt.sts[IRQ_EXT] = 1'b1;
        end

        // Write address and data channels, either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = 8'(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_r.bvalid && s_axi_bready)
            st_nxt.bvalid = 1'b0;

        // Read channel
        if (st_r.rvalid && s_axi_rready)
            st_nxt.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = known_addr(rd_addr) ? RESP_OKAY : RESP_SLVERR;
            case (rd_addr)
                OFS_CONTROL: st_nxt.rdata = {24'h00_0000, st_r.ctrl};
                OFS_COUNT: st_nxt.rdata = {16'h0000, st_r.count};
                OFS_RELOAD: st_nxt.rdata = {16'h0000, st_r.reload};
                OFS_MODE: st_nxt.rdata = {31'h0000_0000, st_r.down_en};
                OFS_POWER: st_nxt.rdata = {30'h0000_0000, st_r.pwr};
                OFS_IRQ_STATUS: st_nxt.rdata = {30'h0000_0000, st_r.sts};
                OFS_IRQ_ENABLE: st_nxt.rdata = {30'h0000_0000, st_r.ien};
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.ctrl <= RST_CONTROL;
            st_r.count <= RST_COUNT;
            st_r.reload <= RST_RELOAD;
            st_r.cnt_in_d <= 1'b1;
            st_r.trig_d <= 1'b1;
        end
        else if (ce)
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready = ~st_r.aw_got & ~st_r.bvalid;
    assign s_axi_wready = ~st_r.w_got & ~st_r.bvalid;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = ~st_r.rvalid;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign aux_overflow_pulse = st_r.ovf_pulse;
    // Baud pulses still run while the overflow flag is held off
    assign uart_a_rx_clock = st_r.ctrl[CTL_A_RX] ? st_r.ovf_pulse
                                                 : timer1_overflow;
    assign uart_a_tx_clock = st_r.ctrl[CTL_A_TX] ? st_r.ovf_pulse
                                                 : timer1_overflow;
    assign uart_b_rx_clock = st_r.pwr[PWR_B_RX] ? st_r.ovf_pulse
                                                : timer1_overflow;
    assign uart_b_tx_clock = st_r.pwr[PWR_B_TX] ? st_r.ovf_pulse
                                                : timer1_overflow;
    assign timer_irq = st_r.ctrl[CTL_OVF] | st_r.ctrl[CTL_EXT];
    assign irq = |(st_r.sts & st_r.ien);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_capture_wrap: assert property (
        ce && !wr_go && !ext_evt && capture_mode && roll
        |=> st_r.count == 16'h0000 && st_r.ctrl[CTL_OVF])
        else $error("capture mode wrap did not clear count and flag");

    a_capture_copy: assert property (
        ce && !wr_go && ext_evt && capture_mode
        |=> st_r.reload == $past(st_r.count) && st_r.ctrl[CTL_EXT])
        else $error("trigger edge did not capture the count");

    a_reload_roll: assert property (
        ce && !wr_go && !baud && !capture_mode && !count_down && roll
        |=> st_r.count == $past(st_r.reload) && st_r.ctrl[CTL_OVF])
        else $error("rollover did not reload and flag");

    a_trig_reload: assert property (
        ce && !wr_go && ext_evt && !baud && !capture_mode
        |=> st_r.count == $past(st_r.reload))
        else $error("trigger edge did not force a reload");

    a_baud_no_ovf: assert property (
        ce && baud && !st_r.ctrl[CTL_OVF] && !wr_go
        |=> !st_r.ctrl[CTL_OVF])
        else $error("overflow flag set during baud operation");

    a_ext_sticky: assert property (
        ce && st_r.ctrl[CTL_EXT] && !wr_go
        |=> st_r.ctrl[CTL_EXT] && timer_irq)
        else $error("external flag dropped without software");

    a_run_hold: assert property (
        ce && !st_r.ctrl[CTL_RUN] && !ext_evt && !wr_go
        |=> $stable(st_r.count))
        else $error("count moved while stopped");

    a_baud_pulse: assert property (
        ce && !wr_go && baud && roll && !ext_evt
        |=> aux_overflow_pulse && st_r.count == $past(st_r.reload))
        else $error("baud overflow did not reload and pulse");

    a_down_count: assert property (
        ce && !wr_go && !ext_evt && count_down && st_r.ctrl[CTL_RUN]
        && tick && !roll
        |=> st_r.count == $past(st_r.count) - 16'h0001)
        else $error("down count did not decrement");

    a_baud_trig: assert property (
        ce && !wr_go && baud && ext_evt && !st_r.ctrl[CTL_RUN]
        |=> $stable(st_r.count) && $stable(st_r.reload)
            && st_r.ctrl[CTL_EXT])
        else $error("baud trigger edge changed count or missed flag");

    a_trig_ignored: assert property (
        ce && !wr_go && trig_fall && !st_r.ctrl[CTL_EXEN]
        |=> $stable(st_r.reload) && $stable(st_r.ctrl[CTL_EXT]))
        else $error("trigger edge acted with the enable clear");

    a_count_hold: assert property (
        ce && !wr_go && !ext_evt && st_r.ctrl[CTL_CSEL]
        && (external_count_input || !st_r.cnt_in_d)
        |=> $stable(st_r.count))
        else $error("count moved without a count pin fall");

    // A low enable must freeze the bus side as well as the timer
    a_ce_freeze: assert property (
        !ce |=> $stable(st_r))
        else $error("state moved while the clock enable was low");

endmodule

// file: verif/atc_pin_model.sv
// Pin-side model: count pin, trigger pin and the other timer's rollover
`timescale 1ns/10ps
module atc_pin_model
(
    input wire logic clock,
    output logic external_count_input,
    output logic external_trigger_input,
    output logic timer1_overflow
);
    logic [2:0] div_r = 3'h0;
    initial external_count_input = 1'b1;
    initial external_trigger_input = 1'b1;
    initial timer1_overflow = 1'b0;
    // Other timer rolls every 5 clocks so a 20-clock window holds 4 pulses
    always @(posedge clock)
    begin
        div_r <= (div_r == 3'h4) ? 3'h0 : div_r + 3'h1;
        timer1_overflow <= (div_r == 3'h4);
    end
    // Pins stay low and high 2 clocks each so every fall is sampled
    task automatic count_fall(input int n);
        repeat (n)
        begin
            @(posedge clock) external_count_input <= 1'b0;
            repeat (2) @(posedge clock);
            external_count_input <= 1'b1;
            repeat (2) @(posedge clock);
        end
    endtask
    task automatic trig_fall();
        @(posedge clock) external_trigger_input <= 1'b0;
        repeat (2) @(posedge clock);
        external_trigger_input <= 1'b1;
        repeat (2) @(posedge clock);
    endtask
    task automatic trig_level(input logic v);
        @(posedge clock) external_trigger_input <= v;
    endtask
endmodule

// file: verif/tb_aux_timer_capture_reload_baud.sv
// Self-checking bench for the auxiliary timer through its register bus
`timescale 1ns/10ps
module tb_aux_timer_capture_reload_baud;
    import atc_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic external_count_input, external_trigger_input, timer1_overflow;
    logic uart_a_rx_clock, uart_a_tx_clock, uart_b_rx_clock, uart_b_tx_clock;
    logic aux_overflow_pulse, timer_irq, irq;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int num_errors = 0;
    int tests_run = 0;
    int pc [4];
    logic [31:0] rd;
    logic ce = 1'b1;

    always #2 clock = ~clock;

    atc_timer i_atc_timer (.clock, .rst, .ce, .external_count_input,
        .external_trigger_input, .timer1_overflow, .uart_a_rx_clock,
        .uart_a_tx_clock, .uart_b_rx_clock, .uart_b_tx_clock,
        .aux_overflow_pulse, .timer_irq, .irq, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    atc_pin_model i_atc_pin_model (.clock, .external_count_input,
        .external_trigger_input, .timer1_overflow);

    // ------------------------------------------------------------
    // Compare, bus and closing tasks
    // ------------------------------------------------------------
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_word({31'h0, got}, {31'h0, exp});
    endtask
    // Stepping in after an edge keeps one assignment per signal per step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check_bit(s_axi_bvalid, 1'b1);
        check_word({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [1:0] er);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        check_bit(s_axi_rvalid, 1'b1);
        check_word({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        rd_reg(a, RESP_OKAY);
        check_word(rd, exp);
    endtask
    task automatic wait_pulse();
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end while (aux_overflow_pulse !== 1'b1 && n < 100);
        check_bit(aux_overflow_pulse, 1'b1);
    endtask
    task automatic count_pulses();
        pc = '{0, 0, 0, 0};
        repeat (20)
        begin
            @(posedge clock);
            pc[0] += int'(uart_a_rx_clock);
            pc[1] += int'(uart_a_tx_clock);
            pc[2] += int'(uart_b_rx_clock);
            pc[3] += int'(uart_b_tx_clock);
        end
    endtask
    task automatic done(input string s);
        $display("Test %s ended, mismatches so far %0d", s, num_errors);
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rc(OFS_CONTROL, {24'h0, RST_CONTROL});
        rc(OFS_COUNT, {16'h0, RST_COUNT});
        rc(OFS_RELOAD, {16'h0, RST_RELOAD});
        rc(OFS_IRQ_STATUS, 32'h0);
        rd_reg(8'h20, RESP_SLVERR);
        check_word(rd, 32'h0);
        done("reset");
        wr(OFS_RELOAD, 32'h0000_FFF0);
        wr(OFS_COUNT, 32'h0000_FFF8);
        wr(OFS_CONTROL, 32'h0000_0004);
        wait_pulse();
        rc(OFS_CONTROL, 32'h0000_0084);
        check_bit(timer_irq, 1'b1);
        rd_reg(OFS_COUNT, RESP_OKAY);
        check_word(rd & 32'hFFF0, 32'h0000_FFF0);
        wr(OFS_CONTROL, 32'h0);
        check_bit(timer_irq, 1'b0);
        rd_reg(OFS_COUNT, RESP_OKAY);
        rc(OFS_COUNT, rd);
        wr(OFS_COUNT, 32'h0000_FFFC);
        wr(OFS_CONTROL, 32'h0000_0005);
        wait_pulse();
        rc(OFS_CONTROL, 32'h0000_0085);
        wr(OFS_CONTROL, 32'h0000_0001);
        rd_reg(OFS_COUNT, RESP_OKAY);
        check_word(rd & 32'hFF00, 32'h0);
        done("overflow");
        wr(OFS_CONTROL, 32'h0000_0009);
        wr(OFS_COUNT, 32'h0000_1234);
        i_atc_pin_model.trig_fall();
        rc(OFS_RELOAD, 32'h0000_1234);
        rc(OFS_CONTROL, 32'h0000_0049);
        rc(OFS_COUNT, 32'h0000_1234);
        check_bit(timer_irq, 1'b1);
        wr(OFS_CONTROL, 32'h0000_0001);
        check_bit(timer_irq, 1'b0);
        wr(OFS_COUNT, 32'h0000_5555);
        i_atc_pin_model.trig_fall();
        rc(OFS_RELOAD, 32'h0000_1234);
        rc(OFS_CONTROL, 32'h0000_0001);
        wr(OFS_CONTROL, 32'h0000_0008);
        i_atc_pin_model.trig_fall();
        rc(OFS_COUNT, 32'h0000_1234);
        rc(OFS_CONTROL, 32'h0000_0048);
        done("trigger");
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_COUNT, 32'h0);
        wr(OFS_CONTROL, 32'h0000_0006);
        i_atc_pin_model.count_fall(3);
        rc(OFS_COUNT, 32'h0000_0003);
        // Falls seen while the enable is low must not be counted later
        ce <= 1'b0;
        i_atc_pin_model.count_fall(2);
        ce <= 1'b1;
        rc(OFS_COUNT, 32'h0000_0003);
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_MODE, 32'h1);
        wr(OFS_COUNT, 32'h0000_0100);
        i_atc_pin_model.trig_level(1'b0);
        wr(OFS_CONTROL, 32'h0000_0004);
        wr(OFS_CONTROL, 32'h0);
        rd_reg(OFS_COUNT, RESP_OKAY);
        check_word(rd & 32'hFF00, 32'h0);
        i_atc_pin_model.trig_level(1'b1);
        wr(OFS_MODE, 32'h0);
        done("count source and direction");
        wr(OFS_IRQ_CLEAR, 32'h3);
        rc(OFS_IRQ_STATUS, 32'h0);
        wr(OFS_IRQ_ENABLE, 32'h3);
        check_bit(irq, 1'b0);
        wr(OFS_CONTROL, 32'h0000_0009);
        i_atc_pin_model.trig_fall();
        rc(OFS_IRQ_STATUS, 32'h2);
        check_bit(irq, 1'b1);
        wr(OFS_IRQ_ENABLE, 32'h1);
        check_bit(irq, 1'b0);
        wr(OFS_IRQ_CLEAR, 32'h2);
        wr(OFS_IRQ_ENABLE, 32'h3);
        check_bit(irq, 1'b0);
        rc(OFS_IRQ_STATUS, 32'h0);
        done("interrupt");
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_RELOAD, 32'h0000_FFFE);
        wr(OFS_COUNT, 32'h0000_FFFE);
        count_pulses();
        check_word(pc[0], 32'd4);
        check_word(pc[1], 32'd4);
        check_word(pc[2], 32'd4);
        check_word(pc[3], 32'd4);
        wr(OFS_CONTROL, 32'h0000_0035);
        wr(OFS_POWER, 32'h3);
        count_pulses();
        check_word(pc[0], 32'd10);
        check_word(pc[1], 32'd10);
        check_word(pc[2], 32'd10);
        check_word(pc[3], 32'd10);
        rc(OFS_CONTROL, 32'h0000_0035);
        // Stopped so that a wrong capture or reload shows in the values
        wr(OFS_CONTROL, 32'h0000_0039);
        wr(OFS_COUNT, 32'h0000_1111);
        i_atc_pin_model.trig_fall();
        rc(OFS_CONTROL, 32'h0000_0079);
        rc(OFS_RELOAD, 32'h0000_FFFE);
        rc(OFS_COUNT, 32'h0000_1111);
        done("baud");
        complete_run();
    end

    initial
    begin
        #60000;
        num_errors++;
        $display("BAD t=%0t watchdog expired", $time);
        complete_run();
    end
endmodule
